// *** src/mtsr_machine_trap_state_regs.sv ***
`timescale 1ns/100ps
// machine trap state registers: scratch, trap pc and trap cause
//
// Contract
// - scratch register freely read and written
// - trap pc bit zero always reads zero
// - fixed 32-bit alignment clears both low bits
// - switchable alignment masks bit one on read
// - trap return reads masked pc too
// - masked bit one still stores writes
// - trap pc holds every valid address
// - trap entry loads faulting instruction address
// - hardware writes pc/cause only on trap
// - trap entry writes cause code
// - top bit marks interrupt, low bits code
// - unsupported codes need not be kept
// - loads use load codes, stores store codes
// - codes 11,12,13,15 for ecall and page faults
// - 18 software check, 19 hardware error
// - interrupt code 13 is counter overflow
// - only highest priority exception recorded
// - fixed synchronous exception priority order
// - fixed interrupt priority order
module mtsr_machine_trap_state_regs
    import mtsr_pkg::*;
#(
    parameter bit FIXED_ALIGN32 = 1'b0, // only 32-bit alignment supported
    parameter bit DMIS_FIRST    = 1'b1  // data misalign ranks above data faults
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // csr access port
    input  wire logic             csr_en_i,
    input  wire logic [11:0]      csr_addr_i,
    input  wire mtsr_op_e         csr_op_i,
    input  wire mtsr_word_t       csr_wdata_i,
    output mtsr_word_t            csr_rdata_o,
    output logic                  csr_hit_o,
    // alignment mode from isa control
    input  wire logic             align32_i,
    // trap entry
    input  wire logic             trap_i,
    input  wire mtsr_word_t       trap_pc_i,
    input  wire logic [IRQ_W-1:0] irq_req_i,
    input  wire logic [EXC_W-1:0] exc_req_i,
    input  wire logic             data_store_i,
    input  wire logic [1:0]       ecall_priv_i,
    // values seen by the core
    output mtsr_word_t            return_pc_o,
    output mtsr_word_t            cause_o,
    output logic                  trap_taken_o
);
    mtsr_word_t scratch_q;
    mtsr_word_t pc_q;
    mtsr_word_t cause_q;
    mtsr_word_t scratch_d;
    mtsr_word_t pc_d;
    mtsr_word_t cause_d;
    logic       scratch_we;
    logic       pc_we;
    logic       cause_we;
    logic       align32;
    mtsr_word_t trap_cause;
    logic       code_ok;
    logic       sel_scratch;
    logic       sel_pc;
    logic       sel_cause;
    logic       csr_wr;
    mtsr_word_t pc_read;

    // apply csr operation to an old value
    function automatic mtsr_word_t csr_apply(input mtsr_op_e op, input mtsr_word_t old,
                                             input mtsr_word_t wd);
        unique case (op)
            MTSR_OP_WRITE: csr_apply = wd;
            MTSR_OP_SET:   csr_apply = old | wd;
            MTSR_OP_CLEAR: csr_apply = old & ~wd;
            MTSR_OP_NONE:  csr_apply = old;
            default:       csr_apply = old;
        endcase
    endfunction : csr_apply

    // read view of the trap pc under the current alignment
    function automatic mtsr_word_t pc_view(input mtsr_word_t v, input logic a32);
        mtsr_word_t r;
        r    = v;
        r[0] = 1'b0;
        if (a32) begin
            r[1] = 1'b0;
        end
        pc_view = r;
    endfunction : pc_view

    // is this code one that the cause field keeps
    function automatic logic supported(input logic intr, input mtsr_code_t c);
        if (intr) begin
            supported = (c == IRQ_SUPERVISOR_SOFTWARE) || (c == IRQ_MACHINE_SOFTWARE) ||
                        (c == IRQ_SUPERVISOR_TIMER) || (c == IRQ_MACHINE_TIMER) ||
                        (c == IRQ_SUPERVISOR_EXTERNAL) || (c == IRQ_MACHINE_EXTERNAL) ||
                        (c == IRQ_COUNTER_OVERFLOW);
        end else begin
            supported = (c <= EXC_ECALL_SUPERVISOR) || (c == EXC_ECALL_MACHINE) ||
                        (c == EXC_INSTR_PAGE) || (c == EXC_LOAD_PAGE) ||
                        (c == EXC_STORE_PAGE) || (c == EXC_SOFTWARE_CHECK) ||
                        (c == EXC_HARDWARE_ERROR);
        end
    endfunction : supported

    // load or store flavour of a data fault code
    function automatic mtsr_code_t data_code(input logic store, input mtsr_code_t ld_code,
                                             input mtsr_code_t st_code);
        data_code = store ? st_code : ld_code;
    endfunction : data_code

    // one-hot decode of a csr address: {cause, trap pc, scratch}
    function automatic logic [2:0] csr_decode(input logic [11:0] a);
        logic hit_scratch;
        logic hit_pc;
        logic hit_cause;
        hit_scratch = (a == CSR_MACHINE_SCRATCH);
        hit_pc      = (a == CSR_MACHINE_TRAP_PC);
        hit_cause   = (a == CSR_MACHINE_TRAP_CAUSE);
        csr_decode  = {hit_cause, hit_pc, hit_scratch};
    endfunction : csr_decode

    // alignment mode in force
    assign align32 = FIXED_ALIGN32 | align32_i;

    // address decode shared by write enables, read mux and hit flag
    assign {sel_cause, sel_pc, sel_scratch} = csr_decode(csr_addr_i);
    assign csr_wr                           = csr_en_i && (csr_op_i != MTSR_OP_NONE);

    // one masked view of the trap pc, so software reads and the
    // trap return address can never disagree about bit one
    assign pc_read = pc_view(pc_q, align32);

    // interrupt and exception priority selection
    // any pending interrupt outranks every synchronous exception
    always_comb begin
        mtsr_code_t c;
        logic       intr;
        c    = EXC_INSTR_MISALIGNED;
        intr = 1'b0;
        if (|irq_req_i) begin
            intr = 1'b1;
            // fixed order, highest first
            if (irq_req_i[IRQ_MEI]) begin
                c = IRQ_MACHINE_EXTERNAL;
            end else if (irq_req_i[IRQ_MSI]) begin
                c = IRQ_MACHINE_SOFTWARE;
            end else if (irq_req_i[IRQ_MTI]) begin
                c = IRQ_MACHINE_TIMER;
            end else if (irq_req_i[IRQ_SEI]) begin
                c = IRQ_SUPERVISOR_EXTERNAL;
            end else if (irq_req_i[IRQ_SSI]) begin
                c = IRQ_SUPERVISOR_SOFTWARE;
            end else if (irq_req_i[IRQ_STI]) begin
                c = IRQ_SUPERVISOR_TIMER;
            end else begin
                c = IRQ_COUNTER_OVERFLOW;
            end
        end else begin
            // one exception reported, highest first
            if (exc_req_i[X_IBRK]) begin
                c = EXC_BREAKPOINT;
            end else if (exc_req_i[X_IPAGE]) begin
                c = EXC_INSTR_PAGE;
            end else if (exc_req_i[X_IACC]) begin
                c = EXC_INSTR_ACCESS;
            end else if (exc_req_i[X_ILL]) begin
                c = EXC_ILLEGAL_INSTR;
            end else if (exc_req_i[X_IMIS]) begin
                c = EXC_INSTR_MISALIGNED;
            end else if (exc_req_i[X_ECALL]) begin
                // the unused privilege code falls back to machine mode
                unique case (ecall_priv_i)
                    PRIV_USER:       c = EXC_ECALL_USER;
                    PRIV_SUPERVISOR: c = EXC_ECALL_SUPERVISOR;
                    PRIV_MACHINE:    c = EXC_ECALL_MACHINE;
                    default:         c = EXC_ECALL_MACHINE;
                endcase
            end else if (exc_req_i[X_EBRK] || exc_req_i[X_DBRK]) begin
                c = EXC_BREAKPOINT;
            end else if (DMIS_FIRST && exc_req_i[X_DMIS]) begin
                c = data_code(data_store_i, EXC_LOAD_MISALIGNED, EXC_STORE_MISALIGNED);
            end else if (exc_req_i[X_DPAGE]) begin
                c = data_code(data_store_i, EXC_LOAD_PAGE, EXC_STORE_PAGE);
            end else if (exc_req_i[X_DACC]) begin
                c = data_code(data_store_i, EXC_LOAD_ACCESS, EXC_STORE_ACCESS);
            end else if (exc_req_i[X_DMIS]) begin
                // misaligned data ranks after the faults when so configured
                c = data_code(data_store_i, EXC_LOAD_MISALIGNED, EXC_STORE_MISALIGNED);
            end else if (exc_req_i[X_SWCHK]) begin
                c = EXC_SOFTWARE_CHECK;
            end else begin
                c = EXC_HARDWARE_ERROR;
            end
        end
        trap_cause          = '0;
        trap_cause[INT_BIT] = intr;
        trap_cause[CODE_W-1:0] = c;
    end

    // write enables from csr access; a trap also loads pc and cause
    assign scratch_we = csr_wr && sel_scratch;
    assign pc_we      = trap_i || (csr_wr && sel_pc);
    assign cause_we   = trap_i || (csr_wr && sel_cause);
    assign scratch_d  = csr_apply(csr_op_i, scratch_q, csr_wdata_i);

    // trap pc next value; trap entry outranks software write, since the
    // handler must see where the trap hit even if an access raced it;
    // set and clear work on the stored bit one, never the masked view
    always_comb begin
        if (trap_i) begin
            pc_d = trap_pc_i;
        end else begin
            pc_d = csr_apply(csr_op_i, pc_view(pc_q, 1'b0), csr_wdata_i);
        end
        pc_d[0] = 1'b0;
        if (FIXED_ALIGN32) begin
            pc_d[1] = 1'b0;
        end
        // full width kept so every valid address fits
    end

    // cause next value; unsupported software codes clear the code
    // keeping the interrupt bit lets a handler still tell the two kinds apart
    always_comb begin
        mtsr_word_t w;
        w       = csr_apply(csr_op_i, cause_q, csr_wdata_i);
        code_ok = supported(w[INT_BIT], w[CODE_W-1:0]) && (w[INT_BIT-1:CODE_W] == '0);
        if (trap_i) begin
            cause_d = trap_cause;
        end else if (code_ok) begin
            cause_d = w;
        end else begin
            cause_d          = '0;
            cause_d[INT_BIT] = w[INT_BIT];
        end
    end

    // storage words; only csr writes ever reach the scratch word
    mtsr_word_reg u_scratch (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .we_i    (scratch_we),
        .wdata_i (scratch_d),
        .q_o     (scratch_q)
    );

    mtsr_word_reg u_trap_pc (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .we_i    (pc_we),
        .wdata_i (pc_d),
        .q_o     (pc_q)
    );

    mtsr_word_reg u_trap_cause (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .we_i    (cause_we),
        .wdata_i (cause_d),
        .q_o     (cause_q)
    );

    // registered csr read, old value before any write this cycle
    // unmapped addresses answer zero with no hit, so strays stay visible
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            csr_rdata_o <= '0;
            csr_hit_o   <= 1'b0;
        end else begin
            csr_hit_o <= csr_en_i && (sel_scratch || sel_pc || sel_cause);
            if (!csr_en_i) begin
                csr_rdata_o <= '0;
            end else if (sel_scratch) begin
                csr_rdata_o <= scratch_q;
            end else if (sel_pc) begin
                csr_rdata_o <= pc_read;
            end else if (sel_cause) begin
                csr_rdata_o <= cause_q;
            end else begin
                csr_rdata_o <= '0;
            end
        end
    end

    // core-side views, one cycle after the stored value
    // the return address is masked too, so trap return never lands
    // on a half-word target while 32-bit alignment is in force
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            return_pc_o  <= '0;
            cause_o      <= '0;
            trap_taken_o <= 1'b0;
        end else begin
            return_pc_o  <= pc_read;
            cause_o      <= cause_q;
            trap_taken_o <= trap_i;
        end
    end
endmodule : mtsr_machine_trap_state_regs

// *** src/mtsr_pkg.sv ***
// constants for the machine trap state registers
package mtsr_pkg;
    localparam int unsigned MACHINE_REGISTER_WIDTH = 64;
    localparam int unsigned CODE_W                 = 6;
    localparam int unsigned IRQ_W                  = 7;
    localparam int unsigned EXC_W                  = 13;
    localparam logic [11:0] CSR_MACHINE_SCRATCH    = 12'h340;
    localparam logic [11:0] CSR_MACHINE_TRAP_PC    = 12'h341;
    localparam logic [11:0] CSR_MACHINE_TRAP_CAUSE = 12'h342;
    localparam int unsigned INT_BIT                = MACHINE_REGISTER_WIDTH - 1;
    typedef logic [MACHINE_REGISTER_WIDTH-1:0] mtsr_word_t;
    typedef logic [CODE_W-1:0]                 mtsr_code_t;
    // csr operation
    typedef enum logic [3:0] {
        MTSR_OP_NONE  = 4'h1,
        MTSR_OP_WRITE = 4'h2,
        MTSR_OP_SET   = 4'h4,
        MTSR_OP_CLEAR = 4'h8
    } mtsr_op_e;
    // interrupt codes
    localparam mtsr_code_t IRQ_SUPERVISOR_SOFTWARE = 6'h01;
    localparam mtsr_code_t IRQ_MACHINE_SOFTWARE    = 6'h03;
    localparam mtsr_code_t IRQ_SUPERVISOR_TIMER    = 6'h05;
    localparam mtsr_code_t IRQ_MACHINE_TIMER       = 6'h07;
    localparam mtsr_code_t IRQ_SUPERVISOR_EXTERNAL = 6'h09;
    localparam mtsr_code_t IRQ_MACHINE_EXTERNAL    = 6'h0B;
    localparam mtsr_code_t IRQ_COUNTER_OVERFLOW    = 6'h0D;
    // exception codes
    localparam mtsr_code_t EXC_INSTR_MISALIGNED    = 6'h00;
    localparam mtsr_code_t EXC_INSTR_ACCESS        = 6'h01;
    localparam mtsr_code_t EXC_ILLEGAL_INSTR       = 6'h02;
    localparam mtsr_code_t EXC_BREAKPOINT          = 6'h03;
    localparam mtsr_code_t EXC_LOAD_MISALIGNED     = 6'h04;
    localparam mtsr_code_t EXC_LOAD_ACCESS         = 6'h05;
    localparam mtsr_code_t EXC_STORE_MISALIGNED    = 6'h06;
    localparam mtsr_code_t EXC_STORE_ACCESS        = 6'h07;
    localparam mtsr_code_t EXC_ECALL_USER          = 6'h08;
    localparam mtsr_code_t EXC_ECALL_SUPERVISOR    = 6'h09;
    localparam mtsr_code_t EXC_ECALL_MACHINE       = 6'h0B;
    localparam mtsr_code_t EXC_INSTR_PAGE          = 6'h0C;
    localparam mtsr_code_t EXC_LOAD_PAGE           = 6'h0D;
    localparam mtsr_code_t EXC_STORE_PAGE          = 6'h0F;
    localparam mtsr_code_t EXC_SOFTWARE_CHECK      = 6'h12;
    localparam mtsr_code_t EXC_HARDWARE_ERROR      = 6'h13;
    // irq request bit positions, highest priority first
    localparam int unsigned IRQ_MEI = 0;
    localparam int unsigned IRQ_MSI = 1;
    localparam int unsigned IRQ_MTI = 2;
    localparam int unsigned IRQ_SEI = 3;
    localparam int unsigned IRQ_SSI = 4;
    localparam int unsigned IRQ_STI = 5;
    localparam int unsigned IRQ_LCO = 6;
    // exception request bit positions, highest priority first
    localparam int unsigned X_IBRK   = 0;
    localparam int unsigned X_IPAGE  = 1;
    localparam int unsigned X_IACC   = 2;
    localparam int unsigned X_ILL    = 3;
    localparam int unsigned X_IMIS   = 4;
    localparam int unsigned X_ECALL  = 5;
    localparam int unsigned X_EBRK   = 6;
    localparam int unsigned X_DBRK   = 7;
    localparam int unsigned X_DMIS   = 8;
    localparam int unsigned X_DPAGE  = 9;
    localparam int unsigned X_DACC   = 10;
    localparam int unsigned X_SWCHK  = 11;
    localparam int unsigned X_HWERR  = 12;
    // privilege of the caller for environment calls
    localparam logic [1:0] PRIV_USER       = 2'h0;
    localparam logic [1:0] PRIV_SUPERVISOR = 2'h1;
    localparam logic [1:0] PRIV_MACHINE    = 2'h3;
endpackage : mtsr_pkg

// *** src/mtsr_word_reg.sv ***
`timescale 1ns/100ps
// one machine-width storage register, its output read straight from the stored flops
module mtsr_word_reg
    import mtsr_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       we_i,
    input  wire mtsr_word_t wdata_i,
    output mtsr_word_t      q_o
);
    // plain storage, cleared at reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            q_o <= '0;
        end else if (we_i) begin
            q_o <= wdata_i;
        end
    end
endmodule : mtsr_word_reg

// *** tb/mtsr_trap_chk_sva.sv ***
`timescale 1ns/100ps
// concurrent checks on the trap state register ports
module mtsr_trap_chk
    import mtsr_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             csr_en_i,
    input  wire logic [11:0]      csr_addr_i,
    input  wire mtsr_op_e         csr_op_i,
    input  wire mtsr_word_t       csr_wdata_i,
    input  wire mtsr_word_t       csr_rdata_o,
    input  wire logic             align32_i,
    input  wire logic             trap_i,
    input  wire mtsr_word_t       trap_pc_i,
    input  wire logic [IRQ_W-1:0] irq_req_i,
    input  wire mtsr_word_t       return_pc_o,
    input  wire mtsr_word_t       cause_o,
    input  wire logic             trap_taken_o
);
    mtsr_word_t pc_q1, pc_q2;
    logic       cause_wr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // trap address delayed to line up with return_pc_o
    always_ff @(posedge clk_i) begin
        pc_q1 <= trap_pc_i;
        pc_q2 <= pc_q1;
    end
    // software write aimed at the cause register
    assign cause_wr = csr_en_i && csr_addr_i == CSR_MACHINE_TRAP_CAUSE
                      && csr_op_i != MTSR_OP_NONE;
    // scratch written, then read back
    sequence scr_wr_s;
        csr_en_i && csr_addr_i == CSR_MACHINE_SCRATCH && csr_op_i == MTSR_OP_WRITE;
    endsequence
    sequence scr_rd_s;
        csr_en_i && csr_addr_i == CSR_MACHINE_SCRATCH && csr_op_i == MTSR_OP_NONE;
    endsequence
    sequence trap_mei_s;
        trap_i && irq_req_i[IRQ_MEI];
    endsequence
    chk_scratch_back: assert property (
        scr_wr_s ##1 scr_rd_s |=> csr_rdata_o == $past(csr_wdata_i, 2))
        else $error("scratch read-back differs from write");
    chk_ret_bit0: assert property (
        return_pc_o[0] == 1'b0) else $error("return pc bit 0 set");
    chk_read_mask: assert property (
        csr_en_i && csr_addr_i == CSR_MACHINE_TRAP_PC && align32_i |=> !csr_rdata_o[1])
        else $error("pc read bit 1 not masked");
    chk_ret_mask: assert property (
        $past(align32_i) |-> !return_pc_o[1]) else $error("return pc bit 1 not masked");
    chk_trap_echo: assert property (
        trap_i |=> trap_taken_o) else $error("trap not echoed");
    chk_no_echo: assert property (
        !trap_i |=> !trap_taken_o) else $error("spurious trap echo");
    chk_trap_pc: assert property (
        trap_i |-> ##2 return_pc_o[63:2] == pc_q2[63:2]) else $error("trap pc not loaded");
    chk_irq_top: assert property (
        trap_mei_s |-> ##2 cause_o == {1'b1, 57'h0, IRQ_MACHINE_EXTERNAL})
        else $error("external irq cause wrong");
    chk_exc_flag: assert property (
        trap_i && irq_req_i == '0 |-> ##2 !cause_o[INT_BIT])
        else $error("exception flagged as interrupt");
    chk_cause_hold: assert property (
        !trap_i && !cause_wr |-> ##2 $stable(cause_o)) else $error("cause changed unasked");
endmodule : mtsr_trap_chk

bind mtsr_machine_trap_state_regs mtsr_trap_chk u_chk (.clk_i, .rstn_i, .csr_en_i,
    .csr_addr_i, .csr_op_i, .csr_wdata_i, .csr_rdata_o, .align32_i, .trap_i, .trap_pc_i,
    .irq_req_i, .return_pc_o, .cause_o, .trap_taken_o);

// *** tb/mtsr_core_model.sv ***
`timescale 1ns/100ps
// core-side trap source: one-cycle trap, noise on fields otherwise
module mtsr_core_model
    import mtsr_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             fire_i,
    input  wire mtsr_word_t       pc_i,
    input  wire logic [IRQ_W-1:0] irq_i,
    input  wire logic [EXC_W-1:0] exc_i,
    input  wire logic             store_i,
    input  wire logic [1:0]       priv_i,
    output logic                  trap_o,
    output mtsr_word_t            pc_o,
    output logic [IRQ_W-1:0]      irq_o,
    output logic [EXC_W-1:0]      exc_o,
    output logic                  store_o,
    output logic [1:0]            priv_o
);
    mtsr_word_t noise_q = 64'hA5C3_0F96_5A3C_F069;
    // changing pattern so stale fields never look valid
    always @(posedge clk_i) noise_q <= {noise_q[62:0], ~noise_q[63]};
    // fields qualified only while the trap pulse is up
    always_comb begin
        trap_o  = fire_i;
        pc_o    = fire_i ? pc_i : noise_q;
        irq_o   = fire_i ? irq_i : noise_q[IRQ_W-1:0];
        exc_o   = fire_i ? exc_i : noise_q[EXC_W+7:8];
        store_o = fire_i ? store_i : noise_q[30];
        priv_o  = fire_i ? priv_i : noise_q[41:40];
    end
endmodule : mtsr_core_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
// self-checking bench for the machine trap state registers
module testbench;
    import mtsr_pkg::*;
    logic             clk_i, rstn_i, csr_en_i, align32_i, fire, st, trap_i, data_store_i;
    logic             csr_hit_o, trap_taken_o;
    logic [11:0]      csr_addr_i;
    logic [1:0]       pv, ecall_priv_i;
    logic [IRQ_W-1:0] irq, irq_req_i;
    logic [EXC_W-1:0] exc, exc_req_i;
    mtsr_op_e         csr_op_i;
    mtsr_word_t       csr_wdata_i, csr_rdata_o, return_pc_o, cause_o, trap_pc_i, tpc;
    mtsr_word_t       scr, pc, cau, w, e, exp_q[$];
    mtsr_code_t       c;
    mtsr_code_t       xc[EXC_W] = '{6'h3, 6'hC, 6'h1, 6'h2, 6'h0, 6'h8, 6'h3, 6'h3, 6'h4,
                                    6'hD, 6'h5, 6'h12, 6'h13};
    mtsr_code_t       ic[IRQ_W] = '{6'hB, 6'h3, 6'h7, 6'h9, 6'h1, 6'h5, 6'hD};
    int               error_cnt, tests_run;
    localparam logic [11:0] SCR = CSR_MACHINE_SCRATCH;
    localparam logic [11:0] PCR = CSR_MACHINE_TRAP_PC;
    localparam logic [11:0] CAR = CSR_MACHINE_TRAP_CAUSE;

    mtsr_machine_trap_state_regs DUT (.clk_i, .rstn_i, .csr_en_i, .csr_addr_i, .csr_op_i,
        .csr_wdata_i, .csr_rdata_o, .csr_hit_o, .align32_i, .trap_i, .trap_pc_i, .irq_req_i,
        .exc_req_i, .data_store_i, .ecall_priv_i, .return_pc_o, .cause_o, .trap_taken_o);
    mtsr_core_model u_core (.clk_i, .fire_i(fire), .pc_i(tpc), .irq_i(irq), .exc_i(exc),
        .store_i(st), .priv_i(pv), .trap_o(trap_i), .pc_o(trap_pc_i), .irq_o(irq_req_i),
        .exc_o(exc_req_i), .store_o(data_store_i), .priv_o(ecall_priv_i));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input string n, input mtsr_word_t ex, input mtsr_word_t s);
        tests_run++;
        if (s !== ex) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, ex, s);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    // cause keeps only supported codes, else just the interrupt bit
    function automatic mtsr_word_t legal(input mtsr_word_t v);
        logic ok;
        ok = v[62:6] == '0 && (v[63] ? v[5:0] inside {1, 3, 5, 7, 9, 11, 13}
             : v[5:0] inside {[0:9], 11, 12, 13, 15, 18, 19});
        return ok ? v : {v[63], 63'h0};
    endfunction : legal
    // one access, noting the answer it must give
    task automatic csr(input logic [11:0] a, input mtsr_op_e op, input mtsr_word_t wd);
        mtsr_word_t raw, nv;
        raw = (a == SCR) ? scr : (a == PCR) ? pc : cau;
        nv  = (op == MTSR_OP_WRITE) ? wd : (op == MTSR_OP_SET) ? raw | wd
            : (op == MTSR_OP_CLEAR) ? raw & ~wd : raw;
        if (a inside {SCR, PCR, CAR})
            exp_q.push_back((a == PCR && align32_i) ? raw & ~64'h2 : raw);
        if (a == SCR) scr = nv;
        if (a == PCR) pc = nv & ~64'h1;
        if (a == CAR) cau = legal(nv);
        csr_en_i    = 1'b1;
        csr_addr_i  = a;
        csr_op_i    = op;
        csr_wdata_i = wd;
        @(negedge clk_i);
    endtask : csr
    // one trap from the core, then read cause and pc back
    task automatic trap(input mtsr_code_t code);
        tpc  = {$urandom, $urandom};
        fire = 1'b1;
        @(negedge clk_i);
        fire = 1'b0;
        check("trap_taken_o", 64'h1, 64'(trap_taken_o));
        pc   = tpc & ~64'h1;
        cau  = {irq != '0, 57'h0, code};
        csr(CAR, MTSR_OP_NONE, '0);
        csr(PCR, MTSR_OP_NONE, '0);
        csr_en_i = 1'b0;
        check("cause_o", cau, cause_o);
        check("return_pc_o", pc, return_pc_o);
    endtask : trap
    // each answer against the oldest note
    always @(negedge clk_i) begin
        if (rstn_i && csr_hit_o === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : ~csr_rdata_o;
            check("csr_rdata_o", e, csr_rdata_o);
        end
    end
    // watchdog
    initial begin
        repeat (2000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end
    // reset, register, mask and trap scenarios
    initial begin
        {csr_en_i, align32_i, fire, st, pv, irq, exc, csr_addr_i, scr, pc, cau} = '0;
        {csr_wdata_i, tpc} = '0;
        csr_op_i  = MTSR_OP_NONE;
        error_cnt = 0;
        tests_run = 0;
        rstn_i    = 1'b0;
        void'($urandom(49));
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        w = {$urandom, $urandom};
        csr(SCR, MTSR_OP_WRITE, w);
        csr(SCR, MTSR_OP_NONE, '0);
        csr(SCR, MTSR_OP_SET, {$urandom, $urandom});
        csr(SCR, MTSR_OP_CLEAR, {$urandom, $urandom});
        csr(12'h343, MTSR_OP_WRITE, ~w);
        csr(SCR, MTSR_OP_NONE, '0);
        csr(PCR, MTSR_OP_WRITE, '1);
        csr(PCR, MTSR_OP_NONE, '0);
        align32_i = 1'b1;
        csr(PCR, MTSR_OP_CLEAR, 64'h4);
        csr(PCR, MTSR_OP_NONE, '0);
        align32_i = 1'b0;
        csr(PCR, MTSR_OP_NONE, '0);
        csr(CAR, MTSR_OP_WRITE, {1'b1, 57'h0, IRQ_COUNTER_OVERFLOW});
        csr(CAR, MTSR_OP_WRITE, 64'hE);
        csr(CAR, MTSR_OP_WRITE, {1'b1, 57'h0, 6'hE});
        csr(CAR, MTSR_OP_SET, 64'h13);
        csr(CAR, MTSR_OP_NONE, '0);
        csr_en_i = 1'b0;
        for (int i = 0; i < EXC_W; i++) begin
            st  = 1'($urandom);
            pv  = 2'($urandom);
            exc = (13'h1 << i) | (13'($urandom) & ~((13'h2 << i) - 13'h1));
            c   = (i == 5) ? (pv == 0 ? 6'h8 : pv == 1 ? 6'h9 : 6'hB)
                : xc[i] + ((st && i inside {[8:10]}) ? 6'h2 : 6'h0);
            trap(c);
        end
        for (int i = 0; i < IRQ_W; i++) begin
            irq = (7'h1 << i) | (7'($urandom) & ~((7'h2 << i) - 7'h1));
            exc = 13'($urandom);
            trap(ic[i]);
        end
        repeat (3) @(negedge clk_i);
        check("pending notes", '0, 64'(exp_q.size()));
        complete_run();
    end
endmodule : testbench
